// ### src/sph_top.sv
// Pin-controlled sleep-hold logic for a two-block programmable logic device.
`default_nettype none
// Overview of operation
// [R1] Enabled option: control pin high means sleep.
// [R2] Sleep captures and holds outputs and state.
// [R3] Outputs floating at entry stay floating.
// [R4] Sleep blocks all inputs except control pin.
// [R5] Pin keepers hold every pin's last level; the code enables keepers on undriven pads only.
// [R6] Option off: control pin is ordinary pin.
// [R7] Control pin's array input unused when enabled.
// [R8] Inputs, enables, clocks valid 10 ns before.
// [R9] Inputs ignored within 5 ns of entry.
// [R10] Inputs accepted again within 2 us.
// [R11] Outputs valid within 2 us, low-drive later.
// [R12] Two control pins, one per block.
// [R13] Active high; low resumes without losing state.
module sph_top
	import sph_pkg::*;
(
	// Clock and reset.
	input  wire logic                ref_clk,
	input  wire logic                resetn,
	// Configuration.
	input  wire logic                sleep_option_en,
	// Device pads; pad_oe_n is low while the pad is driven.
	input  wire logic [NUM_PINS-1:0] pad_in,
	output var  logic [NUM_PINS-1:0] pad_out,
	output var  logic [NUM_PINS-1:0] pad_oe_n,
	// Pin keepers.
	output var  logic [NUM_PINS-1:0] keep_en,
	output var  logic [NUM_PINS-1:0] keep_level,
	// Logic array side.
	input  wire logic [NUM_PINS-1:0] core_out,
	input  wire logic [NUM_PINS-1:0] core_oe,
	output var  logic [NUM_PINS-1:0] core_in,
	// Per-block status.
	output var  logic [NUM_BLOCKS-1:0] core_freeze,
	output var  logic [NUM_BLOCKS-1:0] core_in_valid,
	output var  logic [NUM_BLOCKS-1:0] out_valid,
	output var  logic [NUM_BLOCKS-1:0] out_valid_low
);
	typedef struct packed {
		logic [NUM_PINS-1:0]   pad_out;
		logic [NUM_PINS-1:0]   pad_oe_n;
		logic [NUM_PINS-1:0]   keep_en;
		logic [NUM_PINS-1:0]   keep_level;
		logic [NUM_PINS-1:0]   core_in;
		logic [NUM_BLOCKS-1:0] core_freeze;
		logic [NUM_BLOCKS-1:0] core_in_valid;
		logic [NUM_BLOCKS-1:0] out_valid;
		logic [NUM_BLOCKS-1:0] out_valid_low;
	} sph_top_s;

	sph_top_s s_reg;
	sph_top_s s_next;

	logic [NUM_BLOCKS-1:0] sleep_pin;
	logic [NUM_BLOCKS-1:0] frozen;
	logic [NUM_BLOCKS-1:0] in_valid;
	logic [NUM_BLOCKS-1:0] ctl_out_valid;
	logic [NUM_BLOCKS-1:0] ctl_out_valid_low;
	logic [NUM_BLOCKS-1:0] hold_now;
	logic [NUM_PINS-1:0]   pin_hold;
	logic [NUM_PINS-1:0]   ctl_pin_mask;

	// One control pin per logic block.
	assign sleep_pin[0] = pad_in[SLEEP_PIN_IDX_A]; // [R12]
	assign sleep_pin[1] = pad_in[SLEEP_PIN_IDX_B]; // [R12]

	genvar gb;
	generate
		for (gb = 0; gb < NUM_BLOCKS; gb++)
		begin : g_block
			sph_sleep_ctrl u_ctrl (
				.ref_clk       (ref_clk),
				.resetn        (resetn),
				.option_en     (sleep_option_en),
				.sleep_pin     (sleep_pin[gb]),
				.frozen        (frozen[gb]),
				.in_valid      (in_valid[gb]),
				.out_valid     (ctl_out_valid[gb]),
				.out_valid_low (ctl_out_valid_low[gb])
			);
			// The pin is sampled synchronously, so the hold starts on the very edge
			// that first sees it high, up to one 10 ns clock period after it rises, against the 5 ns cut-off.
			assign hold_now[gb] = frozen[gb] || (sleep_option_en && sleep_pin[gb]); // [R1] [R9]
			assign pin_hold[gb*PINS_PER_BLOCK +: PINS_PER_BLOCK] =
				{PINS_PER_BLOCK{hold_now[gb]}};
		end
	endgenerate

	// With the option on, the control pins never reach the logic array.
	always_comb
	begin
		ctl_pin_mask = PINS_RESET;
		ctl_pin_mask[SLEEP_PIN_IDX_A] = sleep_option_en; // [R7]
		ctl_pin_mask[SLEEP_PIN_IDX_B] = sleep_option_en; // [R7]
	end

	always_comb
	begin
		s_next = s_reg;
		for (int i = 0; i < NUM_PINS; i++)
		begin
			if (pin_hold[i])
			begin
				// Pad drive and enable stay as captured, so a floating
				// output keeps floating and a driven one keeps its value.
				s_next.pad_out[i]  = s_reg.pad_out[i]; // [R2]
				s_next.pad_oe_n[i] = s_reg.pad_oe_n[i]; // [R3]
				// Inputs are blocked; the array sees the last accepted level.
				s_next.core_in[i]  = s_reg.core_in[i]; // [R4]
				// The keeper holds undriven pads at their last level.
				s_next.keep_en[i]  = s_reg.pad_oe_n[i]; // [R5]
			end
			else
			begin
				// Normal operation; the ordinary pin path also serves the
				// control pins when the option is off.
				s_next.pad_out[i]    = core_out[i]; // [R6]
				s_next.pad_oe_n[i]   = !core_oe[i];
				s_next.core_in[i]    = pad_in[i] && !ctl_pin_mask[i]; // [R6] [R7]
				s_next.keep_en[i]    = 1'b0;
				s_next.keep_level[i] = s_reg.pad_oe_n[i] ? pad_in[i] : s_reg.pad_out[i];
			end
		end
		// The array's registers are stopped by the freeze, not reset, so
		// waking up resumes from exactly the held state.
		s_next.core_freeze   = hold_now; // [R2] [R13]
		s_next.core_in_valid = in_valid & ~hold_now; // [R10]
		s_next.out_valid     = ctl_out_valid; // [R11]
		s_next.out_valid_low = ctl_out_valid_low; // [R11]
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s_reg.pad_out       <= PINS_RESET;
			s_reg.pad_oe_n      <= OE_N_RESET;
			s_reg.keep_en       <= PINS_RESET;
			s_reg.keep_level    <= PINS_RESET;
			s_reg.core_in       <= PINS_RESET;
			s_reg.core_freeze   <= 2'h0;
			s_reg.core_in_valid <= 2'h3;
			s_reg.out_valid     <= 2'h3;
			s_reg.out_valid_low <= 2'h3;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign pad_out       = s_reg.pad_out;
	assign pad_oe_n      = s_reg.pad_oe_n;
	assign keep_en       = s_reg.keep_en;
	assign keep_level    = s_reg.keep_level;
	assign core_in       = s_reg.core_in;
	assign core_freeze   = s_reg.core_freeze;
	assign core_in_valid = s_reg.core_in_valid;
	assign out_valid     = s_reg.out_valid;
	assign out_valid_low = s_reg.out_valid_low;
endmodule : sph_top
`default_nettype wire

// ### src/sph_pkg.sv
// Constants shared by the pin-controlled sleep-hold logic.
`default_nettype none
package sph_pkg;
	localparam int NUM_BLOCKS     = 2;
	localparam int PINS_PER_BLOCK = 16;
	localparam int NUM_PINS       = NUM_BLOCKS * PINS_PER_BLOCK;
	// Pin index of each block's dual-purpose sleep control pin.
	localparam int SLEEP_PIN_IDX_A = 6;
	localparam int SLEEP_PIN_IDX_B = 30;
	// Clock and timing figures.
	localparam int CLK_PERIOD_NS = 10;
	localparam int ENTRY_MAX_NS  = 5;
	localparam int WAKE_MAX_US   = 2;
	localparam int LOW_DRIVE_EXTRA_NS = 5;
	// Longest times round down, but never below one cycle.
	localparam int ENTRY_CYC = (ENTRY_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 :
		(ENTRY_MAX_NS / CLK_PERIOD_NS);
	localparam int WAKE_CYC = (WAKE_MAX_US * 1000 / CLK_PERIOD_NS) < 1 ? 1 :
		(WAKE_MAX_US * 1000 / CLK_PERIOD_NS);
	localparam int LOW_DRIVE_CYC = (LOW_DRIVE_EXTRA_NS / CLK_PERIOD_NS) < 1 ? 1 :
		(LOW_DRIVE_EXTRA_NS / CLK_PERIOD_NS);
	localparam int CNT_W = 9;
	localparam logic [CNT_W-1:0] WAKE_CNT_LAST = CNT_W'(WAKE_CYC - 1);
	localparam logic [CNT_W-1:0] LOW_CNT_LAST  = CNT_W'(WAKE_CYC + LOW_DRIVE_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_RESET     = 9'h000;
	localparam logic [NUM_PINS-1:0] PINS_RESET = 32'h00000000;
	localparam logic [NUM_PINS-1:0] OE_N_RESET = 32'hFFFFFFFF;

	typedef enum logic [1:0] {
		SPH_RUN,
		SPH_SLEEP,
		SPH_WAKE
	} sph_state_e;
endpackage : sph_pkg
`default_nettype wire

// ### src/sph_sleep_ctrl.sv
// Per-block sleep sequencer: freeze on the control pin, timed wake-up.
`default_nettype none
module sph_sleep_ctrl
	import sph_pkg::*;
(
	// Clock and reset.
	input  wire logic ref_clk,
	input  wire logic resetn,
	// Control.
	input  wire logic option_en,
	input  wire logic sleep_pin,
	// Status.
	output var  logic frozen,
	output var  logic in_valid,
	output var  logic out_valid,
	output var  logic out_valid_low
);
	typedef struct packed {
		sph_state_e       state;
		logic [CNT_W-1:0] cnt;
		logic             frozen;
		logic             in_valid;
		logic             out_valid;
		logic             out_valid_low;
	} sph_ctrl_s;

	sph_ctrl_s s_reg;
	sph_ctrl_s s_next;

	always_comb
	begin
		s_next = s_reg;
		case (s_reg.state)
			SPH_RUN:
			begin
				if (option_en && sleep_pin)
				begin
					s_next.state         = SPH_SLEEP;
					s_next.frozen        = 1'b1;
					s_next.in_valid      = 1'b0;
					s_next.out_valid     = 1'b0;
					s_next.out_valid_low = 1'b0;
				end
			end
			SPH_SLEEP:
			begin
				// A low level releases the hold; held state is kept as is.
				if (!sleep_pin || !option_en) // [R13]
				begin
					s_next.state = SPH_WAKE;
					s_next.cnt   = CNT_RESET;
				end
			end
			SPH_WAKE:
			begin
				if (option_en && sleep_pin)
				begin
					// The last wake cycle has already raised the valid flags, so re-entry
					// has to drop them again or they would stand through the new hold.
					s_next.state         = SPH_SLEEP;
					s_next.frozen        = 1'b1;
					s_next.in_valid      = 1'b0;
					s_next.out_valid     = 1'b0;
					s_next.out_valid_low = 1'b0;
				end
				else
				begin
					s_next.cnt = s_reg.cnt + 9'h001;
					if (s_reg.cnt == WAKE_CNT_LAST) // [R10] [R11]
					begin
						s_next.frozen    = 1'b0;
						s_next.in_valid  = 1'b1;
						s_next.out_valid = 1'b1;
					end
					if (s_reg.cnt == LOW_CNT_LAST) // [R11]
					begin
						s_next.out_valid_low = 1'b1;
						s_next.state         = SPH_RUN;
					end
				end
			end
			default:
			begin
				s_next.state = SPH_RUN;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s_reg.state         <= SPH_RUN;
			s_reg.cnt           <= CNT_RESET;
			s_reg.frozen        <= 1'b0;
			s_reg.in_valid      <= 1'b1;
			s_reg.out_valid     <= 1'b1;
			s_reg.out_valid_low <= 1'b1;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign frozen        = s_reg.frozen;
	assign in_valid      = s_reg.in_valid;
	assign out_valid     = s_reg.out_valid;
	assign out_valid_low = s_reg.out_valid_low;
endmodule : sph_sleep_ctrl
`default_nettype wire

// ### tb/sph_chk.sv
// Checker for the sleep-hold ports.
`default_nettype none
module sph_chk
	import sph_pkg::*;
(
	// Clock, reset and control.
	input wire logic                  ref_clk, resetn, sleep_option_en,
	// Pads and array side.
	input wire logic [NUM_PINS-1:0]   pad_in, pad_out, pad_oe_n, keep_en, core_in,
	// Block status.
	input wire logic [NUM_BLOCKS-1:0] core_freeze, core_in_valid, out_valid, out_valid_low
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int WAKE_MAX = 203;
	logic ent;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	assign ent = sleep_option_en && pad_in[SLEEP_PIN_IDX_A];
	a_entry_freeze: assert property (ent |=> core_freeze[0] && !core_in_valid[0])
		else $error("block A did not freeze");
	a_out_held: assert property (core_freeze[0] |-> $stable(pad_out[15:0]))
		else $error("held output moved");
	a_hiz_kept: assert property (core_freeze[0] |-> $stable(pad_oe_n[15:0]))
		else $error("held enable moved");
	a_input_block: assert property (core_freeze[0] |-> $stable(core_in[15:0]))
		else $error("held input moved");
	a_keeper_on: assert property (core_freeze[0] |-> keep_en[15:0] == pad_oe_n[15:0])
		else $error("keeper mismatch");
	a_option_off: assert property (!sleep_option_en && !core_freeze[0] |=>
		!core_freeze[0] && core_in[SLEEP_PIN_IDX_A] == $past(pad_in[SLEEP_PIN_IDX_A]))
		else $error("pin not ordinary");
	a_pin_masked: assert property (sleep_option_en |=> !core_in[SLEEP_PIN_IDX_A])
		else $error("control pin reached array");
	a_wake_bound: assert property (core_freeze[0] && !ent |->
		##[1:WAKE_MAX] (!core_freeze[0] || ent))
		else $error("wake too slow");
	a_wake_valid: assert property ($fell(core_freeze[0]) |->
		core_in_valid[0] && out_valid[0] ##1 out_valid_low[0])
		else $error("valid late after wake");
	a_valid_drop: assert property (ent |=> ##1 !out_valid[0])
		else $error("out valid kept in sleep");
	a_block_b: assert property (sleep_option_en && pad_in[SLEEP_PIN_IDX_B] |=>
		core_freeze[1])
		else $error("block B did not freeze");
	c_enter: cover property (ent);
	c_wake: cover property ($fell(core_freeze[0]));
	c_enter_b: cover property (sleep_option_en && pad_in[SLEEP_PIN_IDX_B]);
endmodule : sph_chk
`default_nettype wire

// ### tb/sph_sys.sv
// System-side model driving the pads and both sleep control pins.
`default_nettype none
module sph_sys
	import sph_pkg::*;
(
	// Clock and requests.
	input wire logic                  ref_clk,
	input wire logic [NUM_BLOCKS-1:0] sleep_req,
	input wire logic [NUM_PINS-1:0]   data, pad_out, pad_oe_n,
	// Resolved pads.
	output var logic [NUM_PINS-1:0]   pad_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [NUM_PINS-1:0]   drv_reg = '0, data_smp = '0;
	logic [NUM_BLOCKS-1:0] req_smp = '0, pin_dly = '0, pin_reg = '0;
	// Requests are taken on the rising edge, clear of the bench's falling-edge updates.
	always @(posedge ref_clk)
	begin
		data_smp <= data;
		req_smp  <= sleep_req;
	end
	// Pins trail data by a cycle, so inputs are settled before entry.
	always @(negedge ref_clk)
	begin
		drv_reg <= data_smp;
		pin_dly <= req_smp;
		pin_reg <= pin_dly;
	end
	always_comb
	begin
		pad_in = (pad_oe_n & drv_reg) | (~pad_oe_n & pad_out);
		pad_in[SLEEP_PIN_IDX_A] = pin_reg[0];
		pad_in[SLEEP_PIN_IDX_B] = pin_reg[1];
	end
endmodule : sph_sys
`default_nettype wire

// ### tb/pin_power_down_hold_tb.sv
// Testbench for the pin sleep-hold logic.
`default_nettype none
module pin_power_down_hold_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import sph_pkg::*;
	logic                  ref_clk = 0, resetn = 0, sleep_option_en = 0;
	logic [1:0]            req = 0;
	logic [NUM_PINS-1:0]   data = 0, core_out = 0, core_oe = 0, held;
	logic [NUM_PINS-1:0]   pad_in, pad_out, pad_oe_n, keep_en, keep_level, core_in;
	logic [NUM_BLOCKS-1:0] core_freeze, core_in_valid, out_valid, out_valid_low;
	int                    num_errors = 0, compares = 0, n;
	always #5 ref_clk = ~ref_clk;
	sph_top uut (.ref_clk, .resetn, .sleep_option_en, .pad_in, .pad_out, .pad_oe_n,
		.keep_en, .keep_level, .core_out, .core_oe, .core_in, .core_freeze,
		.core_in_valid, .out_valid, .out_valid_low);
	sph_sys sys (.ref_clk, .sleep_req(req), .data, .pad_out, .pad_oe_n, .pad_in);
	task automatic tick(input int k);
		repeat (k) @(negedge ref_clk);
	endtask : tick
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [31:0] exp_in();
		exp_in = (data & ~core_oe) | (core_out & core_oe);
		exp_in[SLEEP_PIN_IDX_A] = sleep_option_en ? 1'b0 : req[0];
		exp_in[SLEEP_PIN_IDX_B] = sleep_option_en ? 1'b0 : req[1];
	endfunction : exp_in
	task automatic end_of_test();
		$display("compares=%0d num_errors=%0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test
	// Bounded wait for block b to leave hold; a hang ends the run.
	task automatic wake(input int b);
		n = 0;
		while (core_freeze[b] !== 1'b0 && n < WAKE_CYC + 20)
		begin
			tick(1);
			n++;
		end
		chk(32'(n < WAKE_CYC + 6), 1);
		if (n >= WAKE_CYC + 20)
			end_of_test();
	endtask : wake
	task automatic t_off();
		req = 2'b11;
		data = 32'h5A5A_3C3C;
		core_out = 32'h0000_A500;
		core_oe = 32'h0000_FF00;
		tick(4);
		chk(32'(core_freeze), 0);
		chk(core_in, exp_in());
		chk(pad_oe_n, ~core_oe);
		req = 0;
		// Let the control pins settle low before the option is switched on.
		tick(4);
		$display("test option_off done");
	endtask : t_off
	task automatic t_hold();
		sleep_option_en = 1;
		data = 32'h1234_0081;
		tick(4);
		held = core_in;
		chk(held, exp_in());
		req = 2'b01;
		tick(4);
		chk(32'(core_freeze), 1);
		chk(32'(out_valid), 2);
		data = ~data;
		core_out = ~core_out;
		core_oe = 32'h00FF_0000;
		tick(4);
		chk(32'(core_in[15:0]), 32'(held[15:0]));
		chk(32'(pad_oe_n[15:0]), 32'h00FF);
		chk(32'(pad_out[15:8]), 32'hA5);
		chk(32'(keep_en[15:0]), 32'h00FF);
		chk(32'(keep_level[15:0]), 32'hA581);
		chk(32'(core_in[31:16]), exp_in() >> 16);
		req = 0;
		wake(0);
		tick(2);
		chk(32'(out_valid_low), 3);
		chk(core_in, exp_in());
		$display("test hold_wake done");
	endtask : t_hold
	task automatic t_reenter();
		req = 2'b10;
		tick(4);
		req = 0;
		tick(100);
		req = 2'b10;
		tick(150);
		chk(32'(core_freeze), 2);
		req = 0;
		wake(1);
		tick(2);
		chk(32'(out_valid), 3);
		$display("test reenter done");
	endtask : t_reenter
	// Reset in mid-run with block A asleep, then release with its pin still high.
	task automatic t_reset();
		req = 2'b01;
		tick(4);
		resetn = 0;
		tick(2);
		chk(pad_oe_n, 32'hFFFF_FFFF);
		chk(32'(core_freeze), 0);
		chk(32'(out_valid), 3);
		resetn = 1;
		tick(2);
		chk(32'(core_freeze), 1);
		chk(32'(keep_en[15:0]), 32'hFFFF);
		req = 0;
		wake(0);
		$display("test reset_mid done");
	endtask : t_reset
	initial
	begin
		tick(8);
		resetn = 1;
		t_off();
		t_hold();
		t_reenter();
		t_reset();
		end_of_test();
	end
endmodule : pin_power_down_hold_tb
bind sph_top sph_chk u_chk (.ref_clk, .resetn, .sleep_option_en, .pad_in, .pad_out,
	.pad_oe_n, .keep_en, .core_in, .core_freeze, .core_in_valid, .out_valid,
	.out_valid_low);
`default_nettype wire
